// ==== inc/rts_defines.vh ====
/*
 * Constants of the register transfer and shift unit: instruction fields,
 * opcodes, APB register offsets, status and mode bits, reset values.
 * Assumes a 24-bit one's-complement datapath driven by a same-clock
 * instruction sequencer.
 */
`ifndef RTS_DEFINES_VH
`define RTS_DEFINES_VH

// ****************************************************************
// Instruction fields and opcodes
// ****************************************************************
`define RTS_OPC_HI 23
`define RTS_OPC_LO 18
`define RTS_OP_INC 6'h0d
`define RTS_OP_XFER 6'h2b
`define RTS_OP_EXT 6'h2d
`define RTS_OP_STOR 6'h08
`define RTS_OP_SHIFT 6'h0a
`define RTS_IMM_SIGN 14
`define RTS_Z_SIGN 16
`define RTS_FILE_PROT_LIMIT 6'h20
`define RTS_ROT_SPAN 6'h18
`define RTS_ROT_SPAN2 6'h30
`define RTS_RSH_MAX 6'h17

// ****************************************************************
// APB register offsets (byte addresses)
// ****************************************************************
`define RTS_OFF_ACC 8'h00
`define RTS_OFF_QUO 8'h04
`define RTS_OFF_IDX1 8'h08
`define RTS_OFF_IDX2 8'h0c
`define RTS_OFF_IDX3 8'h10
`define RTS_OFF_EXT_LO 8'h14
`define RTS_OFF_EXT_HI 8'h18
`define RTS_OFF_STATUS 8'h1c
`define RTS_OFF_MODE 8'h20

// ****************************************************************
// Status and mode bits, reset values
// ****************************************************************
`define RTS_ST_OVF 0
`define RTS_ST_XINT 1
`define RTS_MD_PROG 0
`define RTS_MD_RIP 1
`define RTS_MD_MON 2
`define RTS_RST_WORD 24'h000000
`define RTS_RST_IDX 15'h0000
`define RTS_RST_MODE 3'h0

`endif

// ==== src/rts_datapath.v ====
/*
 * Register transfer and shift unit: accumulator, quotient, three index
 * registers, 64-word register file and 48-bit extension register, with
 * the increase, transfer, storage-sense and single-register shift
 * instructions, plus an APB slave for software access.
 * Assumes the sequencer on the same clock presents one decoded word with
 * its storage operand and waits for the done pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rts_defines.vh"

module rts_datapath (
	input wire pclk, // Processor clock
	input wire presetn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error on unmapped address
	input wire ins_valid, // Instruction word presented
	input wire [23:0] ins_word, // Instruction word
	output wire ins_ready, // Unit accepts an instruction
	input wire [23:0] mem_operand, // Storage word m for storage shift
	output reg [23:0] mem_wdata, // Rotated storage word
	output reg mem_we, // Write storage word m back
	output reg read_next_instruction, // Instruction completed
	output reg skip_one, // Continue at P+2 instead of P+1
	output reg exec_interrupt, // Executive interrupt request
	output reg clear_realtime_processor, // Clear real-time processor
	output wire overflow // Sticky arithmetic overflow
);

	// ****************************************************************
	// State
	// ****************************************************************
	reg [23:0] acc_q;
	reg [23:0] quo_q;
	reg [47:0] ext_q;
	reg [14:0] idx_q [1:3];
	reg [23:0] file_q [0:63];
	reg [1:0] stat_q;
	reg [2:0] mode_q;
	integer i;

	// ****************************************************************
	// Instruction fields
	// ****************************************************************
	wire [5:0] opc;
	wire [2:0] f3;
	wire [1:0] bsel;
	wire [2:0] sub;
	wire [5:0] vsel;
	wire [14:0] imm;
	wire [14:0] idx_rd;
	wire [23:0] idx_sx;
	wire [23:0] imm_sx;
	wire [23:0] imm_zx;
	wire [23:0] file_rd;

	assign opc = ins_word[`RTS_OPC_HI:`RTS_OPC_LO];
	assign f3 = ins_word[17:15];
	assign bsel = ins_word[16:15];
	assign sub = ins_word[14:12];
	assign vsel = ins_word[5:0];
	assign imm = ins_word[14:0];
	// Designator zero reads as a zero index
	assign idx_rd = (bsel == 2'b00) ? 15'h0000 : idx_q[bsel];
	assign idx_sx = {{9{idx_rd[`RTS_IMM_SIGN]}}, idx_rd};
	assign imm_sx = {{9{imm[`RTS_IMM_SIGN]}}, imm};
	assign imm_zx = {9'h000, imm};
	assign file_rd = file_q[vsel];
	assign ins_ready = 1'b1;

	// ****************************************************************
	// Shared adder
	// ****************************************************************
	reg [23:0] op_x;
	reg [23:0] op_y;
	wire [23:0] sum;
	wire add_ovf;

	always @* begin
		op_x = 24'h000000;
		op_y = 24'h000000;
		case (opc)
			`RTS_OP_INC: begin
				case (f3)
					3'h4: begin
						op_x = acc_q;
						op_y = imm_sx;
					end
					3'h5: begin
						op_x = quo_q;
						op_y = imm_sx;
					end
					3'h6: begin
						op_x = acc_q;
						op_y = imm_zx;
					end
					3'h7: begin
						op_x = quo_q;
						op_y = imm_zx;
					end
					default: begin
						op_x = idx_sx;
						op_y = imm_sx;
					end
				endcase
			end
			`RTS_OP_XFER: begin
				op_x = acc_q;
				// Designator zero in the low half means A plus Q
				op_y = (f3 == 3'h0) ? quo_q : idx_sx;
			end
			`RTS_OP_SHIFT: begin
				// Zero designator still extends the count's sign
				op_x = idx_sx;
				op_y = imm_sx;
			end
			default: begin
				op_x = 24'h000000;
				op_y = 24'h000000;
			end
		endcase
	end

	rts_oc_add #(
		.W(24)
	) u_add (
		.a(op_x),
		.b(op_y),
		.sum(sum),
		.ovf(add_ovf)
	);

	// ****************************************************************
	// Single-register shifter
	// ****************************************************************
	wire [16:0] kcnt;
	wire shr;
	wire [5:0] mag;
	wire [5:0] lmag;
	wire [4:0] rmag;
	wire [23:0] shv;
	wire [47:0] dbl;
	wire [23:0] rotl;
	wire [23:0] sar;

	assign kcnt = sum[16:0];
	assign shr = kcnt[16];
	assign mag = shr ? ~kcnt[5:0] : kcnt[5:0];
	// Reduce so the rotate never exceeds one register length
	assign lmag = (mag >= `RTS_ROT_SPAN2) ? (mag - `RTS_ROT_SPAN2) :
		(mag >= `RTS_ROT_SPAN) ? (mag - `RTS_ROT_SPAN) : mag;
	assign rmag = (mag > `RTS_RSH_MAX) ? 5'h17 : mag[4:0];
	assign shv = f3[2] ? quo_q : acc_q;
	assign dbl = {shv, shv} << lmag;
	assign rotl = dbl[47:24];
	assign sar = $signed(shv) >>> rmag;

	// ****************************************************************
	// Instruction decode and next values
	// ****************************************************************
	reg [23:0] acc_d;
	reg [23:0] quo_d;
	reg [47:0] ext_d;
	reg idx_we;
	reg [14:0] idx_wd;
	reg file_we;
	reg [23:0] file_wd;
	reg ovf_set;
	reg known;
	reg skip_d;
	reg rtclr_d;
	reg mem_we_d;

	always @* begin
		acc_d = acc_q;
		quo_d = quo_q;
		ext_d = ext_q;
		idx_we = 1'b0;
		idx_wd = sum[14:0];
		file_we = 1'b0;
		file_wd = acc_q;
		ovf_set = 1'b0;
		known = 1'b0;
		skip_d = 1'b0;
		rtclr_d = 1'b0;
		mem_we_d = 1'b0;
		case (opc)
			`RTS_OP_INC: begin
				known = 1'b1;
				if (f3 == 3'h4 || f3 == 3'h6) begin
					acc_d = sum;
					ovf_set = add_ovf;
				end else if (f3 == 3'h5 || f3 == 3'h7) begin
					quo_d = sum;
					ovf_set = add_ovf;
				end else if (bsel != 2'b00) begin
					idx_we = 1'b1;
				end else begin
					rtclr_d = mode_q[`RTS_MD_RIP] && mode_q[`RTS_MD_MON];
				end
			end
			`RTS_OP_XFER: begin
				known = 1'b1;
				case (sub)
					3'h0: begin
						if (!f3[2])
							acc_d = {9'h000, idx_rd};
						else if (bsel != 2'b00) begin
							idx_we = 1'b1;
							idx_wd = acc_q[14:0];
						end
					end
					3'h1: begin
						if (f3 == 3'h0)
							quo_d = file_rd;
						else if (f3 == 3'h4) begin
							file_we = 1'b1;
							file_wd = quo_q;
						end else
							known = 1'b0;
					end
					3'h2: begin
						if (f3 == 3'h0)
							acc_d = file_rd;
						else if (f3 == 3'h4) begin
							file_we = 1'b1;
							file_wd = acc_q;
						end else
							known = 1'b0;
					end
					3'h3: begin
						if (!f3[2]) begin
							idx_we = (bsel != 2'b00);
							idx_wd = file_rd[14:0];
						end else begin
							file_we = 1'b1;
							file_wd = {9'h000, idx_rd};
						end
					end
					3'h4: begin
						// Sums here never touch the overflow flag
						if (!f3[2])
							acc_d = sum;
						else
							idx_we = (bsel != 2'b00);
					end
					default: begin
						known = 1'b0;
					end
				endcase
			end
			`RTS_OP_EXT: begin
				known = (f3 != 3'h0) && (f3 != 3'h4);
				case (f3)
					3'h1: quo_d = ext_q[23:0];
					3'h2: acc_d = ext_q[47:24];
					3'h3: begin
						acc_d = ext_q[47:24];
						quo_d = ext_q[23:0];
					end
					3'h5: ext_d = {ext_q[47:24], quo_q};
					3'h6: ext_d = {acc_q, ext_q[23:0]};
					3'h7: ext_d = {acc_q, quo_q};
					default: ext_d = ext_q;
				endcase
			end
			`RTS_OP_STOR: begin
				if (f3 == 3'h0) begin
					known = 1'b1;
					mem_we_d = 1'b1;
					skip_d = mem_operand[23];
				end
			end
			`RTS_OP_SHIFT: begin
				known = 1'b1;
				if (!f3[2])
					acc_d = shr ? sar : rotl;
				else
					quo_d = shr ? sar : rotl;
			end
			default: begin
				known = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	wire apb_wr;
	wire apb_setup;
	wire fire;
	wire xint_d;
	reg mapped;
	reg [31:0] rd_mux;

	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign pslverr = psel && penable && !mapped;
	assign fire = ins_valid && known;
	// Writes into the protected low file words in program state
	assign xint_d = fire && file_we && (vsel < `RTS_FILE_PROT_LIMIT) &&
		mode_q[`RTS_MD_PROG];
	assign overflow = stat_q[`RTS_ST_OVF];

	always @* begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`RTS_OFF_ACC: rd_mux = {8'h00, acc_q};
			`RTS_OFF_QUO: rd_mux = {8'h00, quo_q};
			`RTS_OFF_IDX1: rd_mux = {17'h00000, idx_q[1]};
			`RTS_OFF_IDX2: rd_mux = {17'h00000, idx_q[2]};
			`RTS_OFF_IDX3: rd_mux = {17'h00000, idx_q[3]};
			`RTS_OFF_EXT_LO: rd_mux = {8'h00, ext_q[23:0]};
			`RTS_OFF_EXT_HI: rd_mux = {8'h00, ext_q[47:24]};
			`RTS_OFF_STATUS: rd_mux = {30'h00000000, stat_q};
			`RTS_OFF_MODE: rd_mux = {29'h00000000, mode_q};
			default: mapped = 1'b0;
		endcase
	end

	// Read data is caught in the setup cycle, so it is stable in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (apb_setup)
			prdata <= rd_mux;
	end

	// ****************************************************************
	// Working registers
	// ****************************************************************
	// An executing instruction beats a software write in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= `RTS_RST_WORD;
			quo_q <= `RTS_RST_WORD;
			ext_q <= {`RTS_RST_WORD, `RTS_RST_WORD};
			mode_q <= `RTS_RST_MODE;
		end else begin
			if (fire) begin
				acc_q <= acc_d;
				quo_q <= quo_d;
				ext_q <= ext_d;
			end else if (apb_wr) begin
				if (paddr == `RTS_OFF_ACC)
					acc_q <= pwdata[23:0];
				if (paddr == `RTS_OFF_QUO)
					quo_q <= pwdata[23:0];
				if (paddr == `RTS_OFF_EXT_LO)
					ext_q[23:0] <= pwdata[23:0];
				if (paddr == `RTS_OFF_EXT_HI)
					ext_q[47:24] <= pwdata[23:0];
			end
			if (apb_wr && paddr == `RTS_OFF_MODE)
				mode_q <= pwdata[2:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 1; i <= 3; i = i + 1)
				idx_q[i] <= `RTS_RST_IDX;
		end else begin
			for (i = 1; i <= 3; i = i + 1) begin
				if (fire && idx_we && bsel == i[1:0])
					idx_q[i] <= idx_wd;
				else if (apb_wr &&
					paddr == (`RTS_OFF_IDX1 + {i[5:0], 2'b00} - 8'h04))
					idx_q[i] <= pwdata[14:0];
			end
		end
	end

	// The file is storage and keeps no reset value
	always @(posedge pclk) begin
		if (fire && file_we)
			file_q[vsel] <= file_wd;
	end

	// ****************************************************************
	// Status and completion
	// ****************************************************************
	// Sticky bits clear on a written one; a new event wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_q <= 2'b00;
		else begin
			if (fire && ovf_set)
				stat_q[`RTS_ST_OVF] <= 1'b1;
			else if (apb_wr && paddr == `RTS_OFF_STATUS && pwdata[0])
				stat_q[`RTS_ST_OVF] <= 1'b0;
			if (xint_d)
				stat_q[`RTS_ST_XINT] <= 1'b1;
			else if (apb_wr && paddr == `RTS_OFF_STATUS && pwdata[1])
				stat_q[`RTS_ST_XINT] <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_next_instruction <= 1'b0;
			skip_one <= 1'b0;
			exec_interrupt <= 1'b0;
			clear_realtime_processor <= 1'b0;
			mem_we <= 1'b0;
			mem_wdata <= `RTS_RST_WORD;
		end else begin
			read_next_instruction <= fire;
			skip_one <= fire && skip_d;
			exec_interrupt <= xint_d;
			clear_realtime_processor <= fire && rtclr_d;
			mem_we <= fire && mem_we_d;
			if (fire && mem_we_d)
				mem_wdata <= {mem_operand[22:0], mem_operand[23]};
		end
	end

endmodule

`default_nettype wire

// ==== src/rts_oc_add.v ====
/*
 * One's-complement adder with end-around carry and overflow sense.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none

module rts_oc_add #(
	parameter W = 24
) (
	input wire [W-1:0] a, // First operand
	input wire [W-1:0] b, // Second operand
	output wire [W-1:0] sum, // One's-complement sum
	output wire ovf // Like signs in, other sign out
);

	wire [W:0] raw;
	wire [W:0] fin;

	// End-around carry; a second carry out cannot occur
	assign raw = {1'b0, a} + {1'b0, b};
	assign fin = {1'b0, raw[W-1:0]} + {{W{1'b0}}, raw[W]};
	assign sum = fin[W-1:0];
	assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);

endmodule

`default_nettype wire

// ==== verif/rts_chk.sv ====
/* Port checker for rts_datapath.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module rts_chk (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire psel, // APB select
	input wire penable, // APB access
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB address
	input wire [31:0] pwdata, // APB data
	input wire ins_valid, // Instruction valid
	input wire [23:0] ins_word, // Instruction
	input wire [23:0] mem_operand, // Storage word
	input wire [23:0] mem_wdata, // Rotated word
	input wire mem_we, // Storage write
	input wire read_next_instruction, // Done pulse
	input wire skip_one, // Skip pulse
	input wire exec_interrupt, // Interrupt pulse
	input wire overflow // Sticky overflow
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [5:0] op = ins_word[23:18];
	wire clr = psel && penable && pwrite && paddr == 8'h1c && pwdata[0];
	sequence stor_req;
		ins_valid && op == 6'h08 && ins_word[17:15] == 3'h0;
	endsequence
	sequence stor_ans;
		mem_we && read_next_instruction && skip_one == $past(mem_operand[23]);
	endsequence
	a_stor_sense: assert property (stor_req |=> stor_ans)
		else $error("storage shift answer wrong");
	a_stor_rotate: assert property (stor_req |=> mem_wdata ==
		{$past(mem_operand[22:0]), $past(mem_operand[23])})
		else $error("storage word not rotated");
	a_we_source: assert property (mem_we |-> $past(ins_valid)
		&& $past(op) == 6'h08) else $error("stray storage write");
	a_skip_done: assert property (skip_one |-> read_next_instruction)
		else $error("skip without done");
	a_shift_done: assert property (ins_valid && op == 6'h0a
		|=> read_next_instruction) else $error("shift not completed");
	a_inc_once: assert property (ins_valid && op == 6'h0d ##1 !ins_valid
		|-> read_next_instruction ##1 !read_next_instruction)
		else $error("increase done pulse wrong");
	a_idle_quiet: assert property (!ins_valid |=>
		!read_next_instruction && !mem_we) else $error("pulse while idle");
	a_xint_low: assert property (exec_interrupt |-> read_next_instruction
		&& !$past(ins_word[5])) else $error("interrupt on high word");
	a_ovf_hold: assert property (overflow && !clr |=> overflow)
		else $error("overflow lost");
endmodule
`default_nettype wire

// ==== verif/rts_datapath_tb_top.sv ====
/* Self-checking bench for rts_datapath with a reference model.
   Assumes the sequencer model and the port checker beside it. */
`timescale 1ns/1ps
`default_nettype none
module rts_datapath_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, go = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, seed = 32'd66276;
	logic [23:0] word = 24'h0, mem_in = 24'h0, a = 24'h0, q = 24'h0;
	logic [23:0] rf [64];
	logic [14:0] bx [4] = '{default: 15'h0};
	logic [47:0] e = 48'h0;
	logic [2:0] mode = 3'h0;
	logic [15:0] p_exp = 16'h0;
	logic st_ovf = 1'b0, st_x = 1'b0, x_skip, x_xint, x_rtclr, rec;
	wire [31:0] prdata;
	wire [23:0] ins_word, mem_operand, mem_wdata, mem_q;
	wire [15:0] p_cnt;
	wire [3:0] seen;
	wire pready, pslverr, ins_valid, ins_ready, mem_we, next_ins, skip_one;
	wire xint, rt_clear, overflow, done;
	int n_mismatch = 0, checks_done = 0;
	initial forever #25 pclk = ~pclk;
	rts_datapath rts_datapath_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ins_valid(ins_valid), .ins_word(ins_word),
		.ins_ready(ins_ready), .mem_operand(mem_operand),
		.mem_wdata(mem_wdata), .mem_we(mem_we),
		.read_next_instruction(next_ins),
		.skip_one(skip_one), .exec_interrupt(xint),
		.clear_realtime_processor(rt_clear), .overflow(overflow));
	rts_seq_model rts_seq_model_i (.pclk(pclk), .presetn(presetn),
		.go(go), .word(word), .mem_in(mem_in), .ins_valid(ins_valid),
		.ins_word(ins_word), .mem_operand(mem_operand),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .next_ins(next_ins),
		.skip_one(skip_one), .xint(xint), .rt_clear(rt_clear), .done(done),
		.seen(seen), .mem_q(mem_q), .p_cnt(p_cnt));
	// ********
	// Helpers
	// ********
	function automatic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic [24:0] oca(input [23:0] x, input [23:0] y);
		logic [24:0] t;
		t = x + y;
		t = t[23:0] + t[24];
		return {x[23] == y[23] && t[23] != x[23], t[23:0]};
	endfunction
	function automatic [23:0] sx(input [14:0] x);
		return {{9{x[14]}}, x};
	endfunction
	task end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input [47:0] s, input [47:0] x);
		checks_done++;
		if (s !== x) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, x, s);
		end
	endtask
	task apb(input logic w, input [7:0] ad, input [31:0] d,
		output [31:0] r, output logic er);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_mismatch++;
			end_sim();
		end
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [7:0] ad, input [31:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, ad, d, r, er);
	endtask
	// ********
	// Model
	// ********
	task model(input [23:0] w, input [23:0] m);
		logic [2:0] f, s;
		logic [1:0] b;
		logic [5:0] v, n;
		logic [24:0] t;
		logic [17:0] k;
		logic [23:0] r, src;
		f = w[17:15];
		b = w[16:15];
		s = w[14:12];
		v = w[5:0];
		rec = 1'b1;
		{x_skip, x_xint, x_rtclr} = 3'h0;
		case (w[23:18])
		6'h0d: if (f < 3'h4) begin
			if (b != 2'h0) begin
				t = oca(sx(bx[b]), sx(w[14:0]));
				bx[b] = t[14:0];
			end else x_rtclr = mode[1] & mode[2];
		end else begin
			src = f[0] ? q : a;
			t = oca(src, f[1] ? {9'h0, w[14:0]} : sx(w[14:0]));
			if (f[0]) q = t[23:0];
			else a = t[23:0];
			st_ovf |= t[24];
		end
		6'h2b: begin
			x_xint = f[2] && s >= 3'h1 && s <= 3'h3 && !v[5] && mode[0];
			case (s)
			3'h0: if (!f[2]) a = {9'h0, bx[b]};
				else if (b != 2'h0) bx[b] = a[14:0];
			3'h1: if (!f[2]) q = rf[v]; else rf[v] = q;
			3'h2: if (!f[2]) a = rf[v]; else rf[v] = a;
			3'h3: if (!f[2]) begin
				if (b != 2'h0) bx[b] = rf[v][14:0];
			end else rf[v] = {9'h0, bx[b]};
			3'h4: if (!f[2]) begin
				t = oca(a, b != 2'h0 ? sx(bx[b]) : q);
				a = t[23:0];
			end else if (b != 2'h0) begin
				t = oca(sx(bx[b]), a);
				bx[b] = t[14:0];
			end
			default: rec = 1'b0;
			endcase
		end
		6'h2d: case (f)
			3'h1: q = e[23:0];
			3'h2: a = e[47:24];
			3'h3: {a, q} = e;
			3'h5: e[23:0] = q;
			3'h6: e[47:24] = a;
			3'h7: e = {a, q};
			default: rec = 1'b0;
			endcase
		6'h0a: begin
			k = {1'b0, bx[b][14], bx[b][14], bx[b]}
				+ {1'b0, w[14], w[14], w[14:0]};
			k = k[16:0] + k[17];
			src = f[2] ? q : a;
			n = ~k[5:0];
			if (k[16]) r = $signed(src) >>> (n > 6'd23 ? 6'd23 : n);
			else r = (src << (k[5:0] % 24)) | (src >> (24 - k[5:0] % 24));
			if (f[2]) q = r;
			else a = r;
		end
		6'h08: if (f == 3'h0) x_skip = m[23]; else rec = 1'b0;
		default: rec = 1'b0;
		endcase
		st_x |= x_xint;
		if (rec) p_exp += x_skip ? 16'h2 : 16'h1;
	endtask
	task run(input [23:0] w, input [23:0] m);
		int i;
		logic [31:0] r;
		logic er;
		logic [23:0] x [8];
		@(posedge pclk);
		go <= 1'b1;
		word <= w;
		mem_in <= m;
		@(posedge pclk);
		go <= 1'b0;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (done !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_mismatch++;
			end_sim();
		end
		model(w, m);
		chk("pulses", seen, {rec, x_skip, x_xint, x_rtclr});
		chk("ovf", overflow, st_ovf);
		chk("ready", ins_ready, 48'h1);
		chk("p", p_cnt, p_exp);
		if (w[23:18] == 6'h08) chk("mem", mem_q, {m[22:0], m[23]});
		x = '{a, q, {9'h0, bx[1]}, {9'h0, bx[2]}, {9'h0, bx[3]},
			e[23:0], e[47:24], {22'h0, st_x, st_ovf}};
		for (i = 0; i < 8; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0, r, er);
			chk($sformatf("reg%0d", i), r, 48'(x[i]));
		end
	endtask
	initial begin
		int k, j;
		logic [31:0] r;
		logic er;
		logic [23:0] w;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 10; k++) begin
			apb(1'b0, 8'(4 * k), 32'h0, r, er);
			chk("reset", r, 48'h0);
			chk("slverr", er, 48'(k == 9));
		end
		for (k = 0; k < 64; k++) begin
			a = 24'(rnd());
			wr(8'h00, 32'(a));
			run({6'h2b, 3'h4, 3'h2, 6'h0, 6'(k)}, 24'h0);
		end
		for (j = 0; j < 400; j++) begin
			if (j % 16 == 0) begin
				mode = 3'(rnd());
				a = 24'(rnd());
				q = 24'(rnd());
				bx[1] = 15'(rnd());
				{st_ovf, st_x} = 2'h0;
				wr(8'h20, 32'(mode));
				wr(8'h00, 32'(a));
				wr(8'h04, 32'(q));
				wr(8'h08, 32'(bx[1]));
				wr(8'h1c, 32'h3);
			end
			w = 24'(rnd());
			case (rnd() % 6)
			0: w = {6'h0d, w[17:0]};
			1: if (w[14:12] == 3'h1 || w[14:12] == 3'h2)
					w = {6'h2b, w[17], 2'h0, w[14:12], 6'h0, w[5:0]};
				else if (w[14:12] == 3'h3)
					w = {6'h2b, w[17:12], 6'h0, w[5:0]};
				else w = {6'h2b, w[17:12], 12'h0};
			2: w = {6'h2d, w[17:15], 15'h0};
			3: w = {6'h0a, w[17:0]};
			4: w = {6'h08, 3'h0, w[14:0]};
			default: w = {6'h3f, w[17:0]};
			endcase
			run(w, 24'(rnd()));
		end
		end_sim();
	end
endmodule
bind rts_datapath rts_chk rts_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .ins_valid(ins_valid), .ins_word(ins_word),
	.mem_operand(mem_operand), .mem_wdata(mem_wdata), .mem_we(mem_we),
	.read_next_instruction(read_next_instruction), .skip_one(skip_one),
	.exec_interrupt(exec_interrupt), .overflow(overflow));
`default_nettype wire

// ==== verif/rts_seq_model.sv ====
/* Sequencer and storage model facing rts_datapath.
   Assumes the bench raises go for one cycle per instruction. */
`timescale 1ns/1ps
`default_nettype none
module rts_seq_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic go, // Issue one instruction
	input wire logic [23:0] word, // Instruction to issue
	input wire logic [23:0] mem_in, // Storage word m
	output logic ins_valid, // To design
	output logic [23:0] ins_word, // To design
	output logic [23:0] mem_operand, // To design
	input wire logic [23:0] mem_wdata, // From design
	input wire logic mem_we, // From design
	input wire logic next_ins, // Done pulse
	input wire logic skip_one, // Skip pulse
	input wire logic xint, // Interrupt pulse
	input wire logic rt_clear, // Real-time clear pulse
	output logic done, // Answer window over
	output logic [3:0] seen, // Pulses seen
	output logic [23:0] mem_q, // Storage word now
	output logic [15:0] p_cnt // Program address
);
	logic [2:0] cnt;
	// Operand is not held outside the instruction cycle
	assign mem_operand = ins_valid ? mem_q : ~mem_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_valid <= 1'b0;
			ins_word <= 24'h0;
			mem_q <= 24'h0;
			cnt <= 3'h0;
			done <= 1'b0;
			seen <= 4'h0;
			p_cnt <= 16'h0;
		end else begin
			ins_valid <= go;
			done <= cnt == 3'h1;
			if (go) begin
				ins_word <= word;
				mem_q <= mem_in;
				cnt <= 3'h4;
				seen <= 4'h0;
			end else begin
				if (cnt != 3'h0)
					cnt <= cnt - 3'h1;
				seen <= seen | {next_ins, skip_one, xint, rt_clear};
			end
			if (mem_we)
				mem_q <= mem_wdata;
			if (next_ins)
				p_cnt <= p_cnt + (skip_one ? 16'h2 : 16'h1);
		end
	end
endmodule
`default_nettype wire
